// file: logic/gcr_pkg.sv
// Register map, field layout and state encoding of the gated clock receiver
`default_nettype none
package gcr_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK = 8'h08;
	localparam logic [7:0] ADDR_DATA0 = 8'h0c;
	localparam logic [7:0] ADDR_DATA1 = 8'h10;
	localparam logic [7:0] ADDR_STATE = 8'h14;
	localparam int CTRL_EN = 0;
	localparam int CTRL_MSB = 1;
	localparam int CTRL_INTCLK = 2;
	localparam int CTRL_INTFS = 3;
	localparam int CTRL_LEN_LSB = 8;
	localparam int CTRL_DIV_LSB = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_1000;
	localparam int ST_RXDONE = 0;
	localparam int ST_FRAME = 1;
	localparam int ST_OVR = 2;
	localparam logic [2:0] STATUS_RESET = 3'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [5:0] LEN_MIN = 6'h03;
	localparam logic [5:0] LEN_MAX = 6'h20;
	localparam logic [5:0] LEN_RESET = 6'h10;
	localparam logic [1:0] SYNC_EDGES = 2'h2;
	typedef enum logic [1:0] {
		GCR_IDLE = 2'b00,
		GCR_ARM = 2'b01,
		GCR_SYNC = 2'b11,
		GCR_RECV = 2'b10
	} gcr_state_t;
endpackage
`default_nettype wire

// file: logic/gcr_receiver.sv
// Gated clock synchronous serial receiver with AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RQ1] Word length programmable from 3 to 32 bits.
// [RQ2] Words shift either LSB first or MSB first.
// [RQ3] Bit clock and frame sync each internal or external.
// [RQ4] Serial logic runs from the core clock, no slower clock domain.
// [RQ5] Primary and secondary receive channels work side by side.
// [RQ6] Received words can be moved by DMA without the processor.
// [RQ7] Gated master toggles bit clock only while shifting data.
// [RQ8] External bit clock: first two edges only synchronise, no capture.
// [RQ9] Master drives on falling edges, port samples on rising edges.
// [RQ10] With 15 bits, first word ends on second word's first rise.
// [RQ11] Length written in first receive service applies from third word.
// [RQ12] First frame sync also raises the external interrupt line.
// [RQ13] Software reprograms length only after the two sync edges.
// [RQ14] With 14 bits, first word ends with first transmitted word.
// [RQ15] Length written in frame interrupt applies once second word starts.
// [RQ16] First receive service change: controller drops two dummy words.
// [RQ17] Frame interrupt change: controller drops one dummy word.
// [RQ18] Receive-complete interrupt raised for every assembled word.
module gcr_receiver #(
	parameter int DATA_W = 32
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Serial pins
	input wire logic bitClkIn,
	output logic bitClkOut,
	output logic bitClkOe,
	input wire logic frameSyncIn,
	output logic frameSyncOut,
	output logic frameSyncOe,
	input wire logic rxData0In,
	input wire logic rxData1In,
	// Interrupts and DMA
	output logic irq,
	output logic externalInterruptLine,
	output logic dmaReq,
	input wire logic dmaAck
);
	typedef struct packed {
		logic bclkMeta;
		logic bclkSamp;
		logic bclkPrev;
		logic fsMeta;
		logic fsSamp;
		logic fsPrev;
		logic d0Meta;
		logic d0Samp;
		logic d1Meta;
		logic d1Samp;
		logic [31:0] ctrl;
		logic [2:0] status;
		logic [2:0] mask;
		gcr_pkg::gcr_state_t state;
		logic [1:0] syncCnt;
		logic [5:0] bitCnt;
		logic [5:0] activeLen;
		logic [DATA_W-1:0] shift0;
		logic [DATA_W-1:0] shift1;
		logic [DATA_W-1:0] rxData0;
		logic [DATA_W-1:0] rxData1;
		logic rxFull;
		logic [7:0] divCnt;
		logic bclkGen;
		logic fsGen;
		logic framed;
		logic extIrq;
		logic wrPend;
		logic [7:0] wrAddr;
		logic [31:0] hrdata;
	} gcr_regs_t;

	gcr_regs_t r;
	gcr_regs_t nx;
	logic rstnMeta;
	logic rstnSync;
	logic en;
	logic msbFirst;
	logic intClk;
	logic intFs;
	logic [5:0] progLen;
	logic [7:0] div;
	logic riseEv;
	logic capture;
	logic done;
	logic popEv;
	logic fsLevel;
	logic fsRise;
	logic accept;
	logic [2:0] setStat;
	logic [2:0] clrStat;

	// Lengths outside 3..32 are pulled to the nearest legal one
	function automatic logic [5:0] clampLen(input logic [5:0] raw);
		if (raw < gcr_pkg::LEN_MIN)
			return gcr_pkg::LEN_MIN;
		else if (raw > gcr_pkg::LEN_MAX)
			return gcr_pkg::LEN_MAX;
		else
			return raw;
	endfunction

	function automatic logic [DATA_W-1:0] shiftIn(
		input logic [DATA_W-1:0] sr,
		input logic b,
		input logic msb
	);
		if (msb)
			return {sr[DATA_W-2:0], b};
		else
			return {b, sr[DATA_W-1:1]};
	endfunction

	// LSB-first words enter at the top and must be brought down
	function automatic logic [DATA_W-1:0] alignWord(
		input logic [DATA_W-1:0] sr,
		input logic [5:0] len,
		input logic msb
	);
		logic [5:0] gap;
		logic [DATA_W-1:0] ones;
		gap = 6'h20 - len;
		ones = {DATA_W{1'b1}};
		if (msb)
			return sr & (ones >> gap);
		else
			return sr >> gap;
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rstnMeta <= 1'b0;
			rstnSync <= 1'b0;
		end
		else
		begin
			rstnMeta <= 1'b1;
			rstnSync <= rstnMeta;
		end
	end

	assign en = r.ctrl[gcr_pkg::CTRL_EN];
	assign msbFirst = r.ctrl[gcr_pkg::CTRL_MSB]; // see [RQ2]
	assign intClk = r.ctrl[gcr_pkg::CTRL_INTCLK]; // see [RQ3]
	assign intFs = r.ctrl[gcr_pkg::CTRL_INTFS]; // see [RQ3]
	assign progLen = clampLen(r.ctrl[gcr_pkg::CTRL_LEN_LSB +: 6]); // see [RQ1]
	assign div = r.ctrl[gcr_pkg::CTRL_DIV_LSB +: 8];
	assign accept = hsel && htrans[1] && hready;

	always_comb
	begin
		nx = r;
		riseEv = 1'b0;
		capture = 1'b0;
		done = 1'b0;
		popEv = 1'b0;
		setStat = 3'h0;
		clrStat = 3'h0;
		nx.bclkMeta = bitClkIn; // see [RQ4]
		nx.bclkSamp = r.bclkMeta;
		nx.bclkPrev = r.bclkSamp;
		nx.fsMeta = frameSyncIn;
		nx.fsSamp = r.fsMeta;
		nx.d0Meta = rxData0In;
		nx.d0Samp = r.d0Meta;
		nx.d1Meta = rxData1In;
		nx.d1Samp = r.d1Meta;
		// Internal bit clock runs at sys_clk / (2 * (div + 1))
		if (!en || !intClk)
		begin
			nx.divCnt = 8'h00;
			nx.bclkGen = 1'b0;
		end
		else if (r.divCnt == 8'h00)
		begin
			nx.divCnt = div;
			nx.bclkGen = !r.bclkGen;
		end
		else
			nx.divCnt = r.divCnt - 8'h01;
		// Only rising edges count; falling ones belong to the master
		if (intClk)
			riseEv = en && r.divCnt == 8'h00 && !r.bclkGen; // see [RQ9]
		else
			riseEv = r.bclkSamp && !r.bclkPrev; // see [RQ9]
		fsLevel = intFs ? r.fsGen : r.fsSamp;
		nx.fsPrev = fsLevel;
		fsRise = fsLevel && !r.fsPrev;
		nx.extIrq = 1'b0;
		if (en && fsRise && !r.framed)
		begin
			nx.framed = 1'b1;
			nx.extIrq = 1'b1; // see [RQ12]
			setStat[gcr_pkg::ST_FRAME] = 1'b1; // see [RQ12]
		end
		case (r.state)
			gcr_pkg::GCR_IDLE:
			begin
				nx.framed = 1'b0;
				nx.syncCnt = 2'h0;
				nx.bitCnt = 6'h00;
				nx.activeLen = progLen;
				if (en)
					nx.state = gcr_pkg::GCR_ARM;
			end
			gcr_pkg::GCR_ARM:
				if (riseEv && fsLevel)
				begin
					if (intClk)
					begin
						capture = 1'b1;
						nx.state = gcr_pkg::GCR_RECV;
					end
					else
					begin
						// This edge is swallowed by synchronisation
						nx.syncCnt = 2'h1; // see [RQ8]
						nx.state = gcr_pkg::GCR_SYNC;
					end
				end
			gcr_pkg::GCR_SYNC:
				if (riseEv)
				begin
					if (r.syncCnt + 2'h1 == gcr_pkg::SYNC_EDGES)
						nx.state = gcr_pkg::GCR_RECV; // see [RQ8]
					else
						nx.syncCnt = r.syncCnt + 2'h1;
				end
			gcr_pkg::GCR_RECV:
				capture = riseEv;
			default:
				nx.state = gcr_pkg::GCR_IDLE;
		endcase
		// Words follow back to back; frame sync is not looked at again
		if (capture)
		begin
			nx.shift0 = shiftIn(r.shift0, r.d0Samp, msbFirst); // see [RQ5]
			nx.shift1 = shiftIn(r.shift1, r.d1Samp, msbFirst); // see [RQ5]
			nx.bitCnt = r.bitCnt + 6'h01;
			if (r.bitCnt + 6'h01 == r.activeLen)
				done = 1'b1; // see [RQ10] [RQ14]
		end
		if (done)
		begin
			nx.rxData0 = alignWord(nx.shift0, r.activeLen, msbFirst);
			nx.rxData1 = alignWord(nx.shift1, r.activeLen, msbFirst);
			nx.bitCnt = 6'h00;
			// New length is picked up only at a word boundary
			nx.activeLen = progLen; // see [RQ11] [RQ15]
			setStat[gcr_pkg::ST_RXDONE] = 1'b1; // see [RQ18]
		end
		if (r.state == gcr_pkg::GCR_IDLE)
		begin
			nx.shift0 = '0;
			nx.shift1 = '0;
		end
		if (!en)
			nx.state = gcr_pkg::GCR_IDLE;
		nx.fsGen = en && intFs && nx.state != gcr_pkg::GCR_IDLE
			&& nx.bitCnt == 6'h00 && nx.state != gcr_pkg::GCR_SYNC;
		// Register bus: address phase captures, data phase writes
		nx.wrPend = accept && hwrite;
		nx.wrAddr = haddr;
		if (accept && !hwrite)
		begin
			case (haddr)
				gcr_pkg::ADDR_CTRL:
					nx.hrdata = r.ctrl;
				gcr_pkg::ADDR_STATUS:
					nx.hrdata = {29'h0, r.status};
				gcr_pkg::ADDR_MASK:
					nx.hrdata = {29'h0, r.mask};
				gcr_pkg::ADDR_DATA0:
				begin
					nx.hrdata = 32'(r.rxData0);
					popEv = 1'b1; // see [RQ6]
				end
				gcr_pkg::ADDR_DATA1:
					nx.hrdata = 32'(r.rxData1);
				gcr_pkg::ADDR_STATE:
					nx.hrdata = {10'h000, r.rxFull, r.framed, r.syncCnt,
						r.state, 2'h0, r.activeLen, 2'h0, r.bitCnt};
				default:
					nx.hrdata = 32'h0000_0000;
			endcase
		end
		if (r.wrPend)
		begin
			case (r.wrAddr)
				gcr_pkg::ADDR_CTRL:
					nx.ctrl = hwdata;
				gcr_pkg::ADDR_STATUS:
					clrStat = hwdata[2:0];
				gcr_pkg::ADDR_MASK:
					nx.mask = hwdata[2:0];
				default:
					nx.ctrl = r.ctrl;
			endcase
		end
		if (dmaAck)
			popEv = 1'b1; // see [RQ6]
		// A word finishing in the pop cycle keeps the buffer full
		if (done)
		begin
			nx.rxFull = 1'b1;
			if (r.rxFull && !popEv)
				setStat[gcr_pkg::ST_OVR] = 1'b1;
		end
		else if (popEv)
			nx.rxFull = 1'b0;
		// Set wins over a simultaneous write-one-to-clear
		nx.status = (r.status & ~clrStat) | setStat;
	end

	always_ff @(posedge sys_clk or negedge rstnSync)
	begin
		if (!rstnSync)
		begin
			r <= '0;
			r.ctrl <= gcr_pkg::CTRL_RESET;
			r.status <= gcr_pkg::STATUS_RESET;
			r.mask <= gcr_pkg::MASK_RESET;
			r.activeLen <= gcr_pkg::LEN_RESET;
			r.state <= gcr_pkg::GCR_IDLE;
		end
		else
			r <= nx;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r.hrdata;
	assign bitClkOut = r.bclkGen;
	assign bitClkOe = en && intClk;
	assign frameSyncOut = r.fsGen;
	assign frameSyncOe = en && intFs;
	assign irq = |(r.status & r.mask); // see [RQ18]
	assign externalInterruptLine = r.extIrq; // see [RQ12]
	assign dmaReq = r.rxFull; // see [RQ6]

	property p_sync_two;
		@(posedge sys_clk) disable iff (!rstnSync)
		(r.state == gcr_pkg::GCR_SYNC && riseEv && en && !intClk)
		|=> (r.state == gcr_pkg::GCR_RECV && r.bitCnt == 6'h00);
	endproperty
	a_sync_two: assert property (p_sync_two) // see [RQ8]
		else $error("second sync edge did not start reception");

	property p_no_capture_sync;
		@(posedge sys_clk) disable iff (!rstnSync)
		(r.state == gcr_pkg::GCR_SYNC) |=> $stable(r.shift0);
	endproperty
	a_no_capture_sync: assert property (p_no_capture_sync) // see [RQ8]
		else $error("data captured on a synchronisation edge");

	property p_len_range;
		@(posedge sys_clk) disable iff (!rstnSync)
		1'b1 |-> (r.activeLen >= 6'h03 && r.activeLen <= 6'h20);
	endproperty
	a_len_range: assert property (p_len_range) // see [RQ1]
		else $error("active word length out of range");

	property p_len_boundary;
		@(posedge sys_clk) disable iff (!rstnSync)
		$changed(r.activeLen)
		|-> ($past(done) || $past(r.state) == gcr_pkg::GCR_IDLE);
	endproperty
	a_len_boundary: assert property (p_len_boundary) // see [RQ11]
		else $error("word length changed inside a word");

	property p_done_flag;
		@(posedge sys_clk) disable iff (!rstnSync)
		done |=> (r.status[gcr_pkg::ST_RXDONE] && r.rxFull && dmaReq);
	endproperty
	a_done_flag: assert property (p_done_flag) // see [RQ18]
		else $error("completed word not flagged");

	property p_ext_pulse;
		@(posedge sys_clk) disable iff (!rstnSync)
		externalInterruptLine
		|-> (r.status[gcr_pkg::ST_FRAME] && r.framed) ##1 !externalInterruptLine;
	endproperty
	a_ext_pulse: assert property (p_ext_pulse) // see [RQ12]
		else $error("frame interrupt line is not a single pulse");

	property p_msb_last;
		@(posedge sys_clk) disable iff (!rstnSync)
		(done && msbFirst) |=> (r.rxData0[0] == $past(r.d0Samp));
	endproperty
	a_msb_last: assert property (p_msb_last) // see [RQ2]
		else $error("MSB-first word does not end in last bit");

	property p_pop;
		@(posedge sys_clk) disable iff (!rstnSync)
		(accept && !hwrite && haddr == gcr_pkg::ADDR_DATA0 && !done)
		|=> !dmaReq;
	endproperty
	a_pop: assert property (p_pop) // see [RQ6]
		else $error("data read did not release the buffer");

	property p_count_on_rise;
		@(posedge sys_clk) disable iff (!rstnSync)
		($changed(r.bitCnt) && r.state == gcr_pkg::GCR_RECV
			&& $past(r.state) == gcr_pkg::GCR_RECV) |-> $past(riseEv);
	endproperty
	a_count_on_rise: assert property (p_count_on_rise) // see [RQ9]
		else $error("bit counted without a rising edge");
endmodule
`default_nettype wire

// file: dv/gcr_master_model.sv
// Gated bit clock serial master feeding the receiver pins
`timescale 1ns/100ps
`default_nettype none
module gcr_master_model (
	// Control
	input wire logic sys_clk,
	input wire logic start,
	input wire logic [127:0] stream,
	// Serial pins
	output logic bitClk,
	output logic frameSync,
	output logic dat0,
	output logic dat1,
	output logic busy
);
	initial
	begin
		{bitClk, frameSync, dat0, dat1, busy} = 5'h02;
		forever
		begin
			@(posedge sys_clk iff start);
			busy = 1'b1;
			// Odd offset keeps the link out of phase with sys_clk
			#13;
			for (int i = 0; i < 128; i++)
			begin
				if (i % 16 == 0 && i > 0)
				begin
					// Clock parked low between words
					{dat0, dat1} = {~dat0, ~dat1};
					#330;
				end
				// New bit on the falling edge
				dat0 = stream[127-i];
				dat1 = ~stream[127-i];
				frameSync = (i % 16 == 0);
				#200 bitClk = 1'b1;
				#200 bitClk = 1'b0;
			end
			{frameSync, dat0, dat1} = {1'b0, ~dat0, ~dat1};
			busy = 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: dv/gated_clock_serial_receiver_test.sv
// Self-checking bench for the gated clock receiver
`timescale 1ns/100ps
`default_nettype none
module gated_clock_serial_receiver_test;
	logic sys_clk, rstn, hsel, hwrite, dmaAck, start, m;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rd;
	logic [127:0] stream;
	logic hready, hresp, bitClk, frameSync, dat0, dat1, busy;
	logic irq, extIrq, dmaReq, clkOut, clkOe, fsOut, fsOe;
	int bad_count, n_checks, cyc, pos, len;

	gcr_receiver uut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.bitClkIn(bitClk), .bitClkOut(clkOut), .bitClkOe(clkOe),
		.frameSyncIn(frameSync), .frameSyncOut(fsOut), .frameSyncOe(fsOe),
		.rxData0In(dat0), .rxData1In(dat1), .irq(irq),
		.externalInterruptLine(extIrq), .dmaReq(dmaReq), .dmaAck(dmaAck));
	gcr_master_model far (.sys_clk(sys_clk), .start(start),
		.stream(stream), .bitClk(bitClk), .frameSync(frameSync),
		.dat0(dat0), .dat1(dat1), .busy(busy));

	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			bad_count++;
			end_sim;
		end
	end

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	task xf(input logic [7:0] a, input logic w, input logic [31:0] d);
		{hsel, htrans, hwrite} <= {1'b1, 2'h2, w};
		haddr <= a;
		do @(posedge sys_clk); while (hready !== 1'b1);
		{hsel, htrans} <= 3'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	// n-bit word at bit p of the stream once the two sync edges are gone
	function automatic logic [31:0] getw(input logic [127:0] s, input int p,
		input int n, input logic msb);
		logic [31:0] v;
		v = 32'h0;
		for (int i = 0; i < n; i++)
			if (msb)
				v = {v[30:0], s[125-p-i]};
			else
				v[i] = s[125-p-i];
		return v;
	endfunction

	task go;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		@(posedge sys_clk);
	endtask

	task idle;
		for (int t = 0; t < 3000 && busy === 1'b1; t++)
			@(posedge sys_clk);
		xf(gcr_pkg::ADDR_CTRL, 1, 32'h0);
		xf(gcr_pkg::ADDR_STATUS, 1, 32'h7);
	endtask

	task words(input int n, input int l0, input int nOld, input logic msb,
		input logic viaIrq);
		pos = 0;
		for (int k = 0; k < n; k++)
		begin
			len = (k < nOld) ? l0 : 16;
			for (int t = 0; t < 400 && (viaIrq ? irq : dmaReq) !== 1'b1; t++)
				@(posedge sys_clk);
			chk({31'h0, viaIrq ? irq : dmaReq}, 32'h1, "word");
			if (viaIrq)
			begin
				xf(gcr_pkg::ADDR_STATUS, 0, 0);
				chk(rd & 32'h1, 32'h1, "rxdone");
				xf(gcr_pkg::ADDR_STATUS, 1, 32'h7);
			end
			else
				chk({31'h0, irq}, 32'h0, "masked");
			xf(gcr_pkg::ADDR_DATA1, 0, 0);
			chk(rd, getw(~stream, pos, len, msb), "data1");
			if (k % 2 && !viaIrq)
			begin
				dmaAck <= 1'b1;
				@(posedge sys_clk);
				dmaAck <= 1'b0;
				repeat (2) @(posedge sys_clk);
				chk({31'h0, dmaReq}, 32'h0, "pop");
			end
			else
			begin
				xf(gcr_pkg::ADDR_DATA0, 0, 0);
				chk(rd, getw(stream, pos, len, msb), "data0");
			end
			// Length change lands on the third word
			if (k == 0 && nOld == 2)
				xf(gcr_pkg::ADDR_CTRL, 1, 32'h1003);
			repeat (2) @(posedge sys_clk);
			pos += len;
		end
	endtask

	initial
	begin
		{rstn, hsel, hwrite, dmaAck, start} = 5'h0;
		{haddr, htrans, hwdata, stream} = '0;
		{cyc, bad_count, n_checks} = '0;
		void'($urandom(44816));
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		xf(gcr_pkg::ADDR_CTRL, 0, 0);
		chk(rd, gcr_pkg::CTRL_RESET, "ctrl reset");
		chk({31'h0, hresp}, 32'h0, "okay");
		xf(gcr_pkg::ADDR_MASK, 0, 0);
		chk(rd, 32'h0, "mask reset");
		xf(8'h40, 0, 0);
		chk(rd, 32'h0, "hole");
		xf(gcr_pkg::ADDR_CTRL, 1, 32'h100d);
		@(posedge sys_clk);
		chk({30'h0, clkOe, fsOe}, 32'h3, "own clk");
		// Divider zero: own bit clock flips every cycle
		rd[0] = clkOut;
		@(posedge sys_clk);
		chk({31'h0, clkOut ^ rd[0]}, 32'h1, "clk toggle");
		for (int t = 0; t < 40 && fsOut !== 1'b1; t++)
			@(posedge sys_clk);
		chk({31'h0, fsOut}, 32'h1, "own fs");
		xf(gcr_pkg::ADDR_CTRL, 1, 32'h0);
		@(posedge sys_clk);
		chk({30'h0, clkOe, fsOe}, 32'h0, "ext clk");
		// Change inside the first receive service
		stream <= {8{16'hff00}};
		xf(gcr_pkg::ADDR_MASK, 1, 32'h1);
		xf(gcr_pkg::ADDR_CTRL, 1, 32'h0f03);
		go;
		words(8, 15, 2, 1, 1);
		idle;
		// Change inside the frame sync interrupt
		xf(gcr_pkg::ADDR_MASK, 1, 32'h0);
		xf(gcr_pkg::ADDR_CTRL, 1, 32'h0e03);
		go;
		for (int t = 0; t < 100 && extIrq !== 1'b1; t++)
			@(posedge sys_clk);
		chk({31'h0, extIrq}, 32'h1, "ext irq");
		xf(gcr_pkg::ADDR_STATUS, 0, 0);
		chk(rd & 32'h2, 32'h2, "frame");
		repeat (20) @(posedge sys_clk);
		xf(gcr_pkg::ADDR_CTRL, 1, 32'h1003);
		words(8, 14, 1, 1, 0);
		idle;
		repeat (3)
		begin
			len = 3 + $urandom % 30;
			m = $urandom % 2;
			stream <= {$urandom, $urandom, $urandom, $urandom};
			xf(gcr_pkg::ADDR_CTRL, 1, {18'h0, len[5:0], 6'h0, m, 1'b1});
			go;
			words(126 / len, len, 126, m, 0);
			idle;
		end
		end_sim;
	end
endmodule
`default_nettype wire
